//--- design/mucfc_filter_chain.sv
/*
  multicarrier up-converter filter chain: per carrier an interpolate-by-2
  droop compensator and a four-stage interpolate-by-16 cic, then a complex
  mixer that sums all carriers into one 16-bit i/q stream.
  assumes one modulator frame (all carriers at once) offered with a
  valid/ready handshake, and a downstream sink that takes every outValid.
*/
// How it works
// [R1] modulator supplies 12-bit complex samples per carrier
// [R2] input at eight samples per symbol
// [R3] output at 256 samples per symbol
// [R4] total interpolation is 32
// [R5] shaper, compensator, cic, then mixer, in order
// [R6] compensator interpolates by 2, inverse-sinc shaped
// [R7] cic interpolates by 16
// [R8] cic has four integrator/comb pairs
// [R9] cic uses integer adds only, no multipliers
// [R10] shaping stage bypassed, rate change one
// [R11] channels time-shared, mixer is dot product
// [R12] pass 80 kHz, stop from 100 kHz
// [R13] cic rejects images by at least 96 dB
// [R14] output is 16-bit complex
// [R15] 32-bit phase accumulator per carrier
// [R16] compensator has 31 taps
// [R17] comb delay one, widths never overflow
`timescale 1ns/1ps

module mucfc_filter_chain (
  input  wire logic                   sys_clk,      // system clock
  input  wire logic                   rst_n,        // async reset, active low
  input  wire logic                   inValid,      // modulator frame offered
  output logic                        inReady,      // high while idle: a frame offered now is taken
  input  wire mucfc_pkg::mucfc_frame_t inFrame,     // one sample per carrier
  input  wire mucfc_pkg::mucfc_freq_t  carrierFreq, // per-carrier tuning words
  output logic                        outValid,     // one output sample
  output mucfc_pkg::mucfc_out_s       outSample     // multicarrier i/q
);
  import mucfc_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  mucfc_state_e              stateFf, nxt_state;     // sequencer
  logic                      phaseFf, nxt_phase;     // compensator branch
  logic [1:0]                chanFf, nxt_chan;       // carrier in work
  logic [3:0]                tapFf, nxt_tap;         // mac tap counter
  logic [3:0]                stepFf, nxt_step;       // cic output step
  logic [3:0]                wrPtrFf, nxt_wrPtr;     // delay line head
  logic signed [ACC_W-1:0]   accFf [2];              // mac sums, i and q
  logic signed [ACC_W-1:0]   nxt_acc [2];
  logic signed [MIX_W-1:0]   mixFf [2];              // dot product partials
  logic signed [MIX_W-1:0]   nxt_mix [2];
  logic signed [CIC_W-1:0]   combDlyFf [NCH][CIC_STAGES][2]; // comb memories
  logic signed [CIC_W-1:0]   nxt_combDly [NCH][CIC_STAGES][2];
  logic signed [CIC_W-1:0]   integFf [NCH][CIC_STAGES][2];   // integrators
  logic signed [CIC_W-1:0]   nxt_integ [NCH][CIC_STAGES][2];
  logic signed [CIC_W-1:0]   combOutFf [NCH][2];     // comb result held
  logic signed [CIC_W-1:0]   nxt_combOut [NCH][2];
  logic [PHASE_W-1:0]        phaseAccFf [NCH];       // oscillator phases
  logic [PHASE_W-1:0]        nxt_phaseAcc [NCH];
  logic                      outValidFf, nxt_outValid;
  mucfc_out_s                outSampleFf, nxt_outSample;

  // ------------------------------------------------------------------
  // per-carrier delay lines, cleared by reset
  // ------------------------------------------------------------------
  logic signed [IN_W-1:0]    dlMem [NCH][PH_TAPS][2];  // 16 newest inputs
  logic                      dlWrEn;                   // store a frame

  // writes every carrier of the frame at the head slot; the head wraps
  // after sixteen frames, so the oldest sample is simply overwritten.
  // reset clears the history: without it the first frames after reset
  // would multiply unknown slots into the accumulators, and the cic
  // integrators would then carry the bad value forever
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        for (int t = 0; t < PH_TAPS; t++) begin
          dlMem[c][t][0] <= '0;   // empty history reads as silence
          dlMem[c][t][1] <= '0;
        end
      end
    end else if (dlWrEn) begin
      for (int c = 0; c < NCH; c++) begin
        dlMem[c][wrPtrFf][0] <= inFrame[c].i;   // see [R1]
        dlMem[c][wrPtrFf][1] <= inFrame[c].q;
      end
    end
  end

  // ------------------------------------------------------------------
  // oscillator lookup
  // ------------------------------------------------------------------
  // quarter-wave sine of the top six phase bits
  function automatic logic signed [OUT_W-1:0] sinLut(input logic [PHASE_W-1:0] ph);
    logic [4:0] idx;
    logic signed [OUT_W-1:0] mag;
    idx = ph[30] ? (5'd16 - {1'b0, ph[29:26]}) : {1'b0, ph[29:26]};
    mag = SIN_QTR[idx];
    return ph[31] ? -mag : mag;
  endfunction

  // ------------------------------------------------------------------
  // datapath helpers
  // ------------------------------------------------------------------
  logic [3:0]                rdPtr;     // sample read for this tap
  logic [4:0]                coefIdx;   // polyphase coefficient index
  logic signed [OUT_W-1:0]   sinVal;    // current carrier sine
  logic signed [OUT_W-1:0]   cosVal;    // current carrier cosine

  // newest sample sits one behind the head; branch picks odd or even taps
  // tap counter and pointer share four bits, so the backward walk wraps
  // inside the sixteen-slot ring without any compare; the zero pad in the
  // last coefficient slot keeps branch 1 at sixteen taps as well
  assign rdPtr   = wrPtrFf - 4'h1 - tapFf;       // see [R16]
  assign coefIdx = {tapFf, phaseFf};             // see [R6]
  assign sinVal  = sinLut(phaseAccFf[chanFf]);
  assign cosVal  = sinLut(phaseAccFf[chanFf] + QUARTER_TURN);
  assign inReady = (stateFf == ST_IDLE);         // see [R2]

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic signed [CIC_W-1:0] v;
    logic signed [OUT_W-1:0] cicSample [2];
    logic signed [MIX_W-1:0] mixSum [2];
    v            = '0;
    cicSample[0] = '0;
    cicSample[1] = '0;
    mixSum[0]    = '0;
    mixSum[1]    = '0;
    // hold every register by default; the output pulse defaults low
    nxt_state     = stateFf;
    nxt_phase     = phaseFf;
    nxt_chan      = chanFf;
    nxt_tap       = tapFf;
    nxt_step      = stepFf;
    nxt_wrPtr     = wrPtrFf;
    nxt_acc       = accFf;
    nxt_mix       = mixFf;
    nxt_combDly   = combDlyFf;
    nxt_integ     = integFf;
    nxt_combOut   = combOutFf;
    nxt_phaseAcc  = phaseAccFf;
    nxt_outValid  = 1'b0;
    nxt_outSample = outSampleFf;
    dlWrEn        = 1'b0;

    case (stateFf)
      // wait for a frame; shaping stage is a straight pass
      ST_IDLE: begin
        if (inValid) begin                      // see [R10]
          dlWrEn    = 1'b1;
          nxt_wrPtr = wrPtrFf + 4'h1;
          nxt_phase = 1'b0;
          nxt_chan  = '0;
          nxt_tap   = '0;
          nxt_acc[0] = '0;
          nxt_acc[1] = '0;
          nxt_state = ST_MAC;                   // see [R5]
        end
      end

      // one multiply-accumulate per cycle over 16 taps of one branch
      // the sum is kept full width; scaling happens once in the comb step
      // so truncation error is not accumulated tap by tap
      ST_MAC: begin
        for (int k = 0; k < 2; k++) begin
          nxt_acc[k] = accFf[k] + ACC_W'(dlMem[chanFf][rdPtr][k] * CFIR_COEF[coefIdx]); // see [R12] see [R16]
        end
        if (tapFf == 4'(PH_TAPS - 1)) begin
          nxt_state = ST_COMB;
        end else begin
          nxt_tap = tapFf + 4'h1;
        end
      end

      // four comb sections at the low rate, differential delay one
      ST_COMB: begin
        for (int k = 0; k < 2; k++) begin
          v = CIC_W'(accFf[k] >>> CFIR_SHIFT);  // see [R6]
          for (int s = 0; s < CIC_STAGES; s++) begin
            nxt_combDly[chanFf][s][k] = v;      // see [R17]
            v = v - combDlyFf[chanFf][s][k];    // see [R8] see [R9]
          end
          nxt_combOut[chanFf][k] = v;
          nxt_acc[k] = '0;
        end
        nxt_tap = '0;
        if (chanFf == 2'(NCH - 1)) begin        // see [R11]
          nxt_chan  = '0;
          nxt_step  = '0;
          nxt_mix[0] = '0;
          nxt_mix[1] = '0;
          nxt_state = ST_INTEG;
        end else begin
          nxt_chan  = chanFf + 2'h1;
          nxt_state = ST_MAC;
        end
      end

      // zero-stuffed integrators at the high rate, then mix and sum
      ST_INTEG: begin
        for (int k = 0; k < 2; k++) begin
          v = (stepFf == 4'h0) ? combOutFf[chanFf][k] : '0;   // see [R7]
          for (int s = 0; s < CIC_STAGES; s++) begin
            v = integFf[chanFf][s][k] + v;      // see [R8] see [R9] see [R13]
            nxt_integ[chanFf][s][k] = v;
          end
          cicSample[k] = OUT_W'(v >>> CIC_SHIFT);
        end
        // complex rotation of this carrier added to the running sum
        mixSum[0] = mixFf[0] + MIX_W'(cicSample[0] * cosVal) - MIX_W'(cicSample[1] * sinVal); // see [R11]
        mixSum[1] = mixFf[1] + MIX_W'(cicSample[0] * sinVal) + MIX_W'(cicSample[1] * cosVal);
        nxt_phaseAcc[chanFf] = phaseAccFf[chanFf] + carrierFreq[chanFf];   // see [R15]
        if (chanFf == 2'(NCH - 1)) begin
          // all carriers summed: emit one output sample
          nxt_outValid    = 1'b1;               // see [R3]
          nxt_outSample.i = OUT_W'(mixSum[0] >>> MIX_SHIFT);   // see [R14]
          nxt_outSample.q = OUT_W'(mixSum[1] >>> MIX_SHIFT);
          nxt_mix[0] = '0;
          nxt_mix[1] = '0;
          nxt_chan   = '0;
          if (stepFf == 4'(CIC_INTERP - 1)) begin
            nxt_step = '0;
            if (phaseFf == 1'b0) begin
              // second compensator branch: 2 x 16 = 32 outputs per frame
              nxt_phase = 1'b1;                 // see [R4]
              nxt_tap   = '0;
              nxt_state = ST_MAC;
            end else begin
              nxt_state = ST_IDLE;
            end
          end else begin
            nxt_step = stepFf + 4'h1;
          end
        end else begin
          nxt_mix  = mixSum;
          nxt_chan = chanFf + 2'h1;
        end
      end

      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateFf     <= ST_IDLE;
      phaseFf     <= 1'b0;
      chanFf      <= '0;
      tapFf       <= '0;
      stepFf      <= '0;
      wrPtrFf     <= '0;
      outValidFf  <= 1'b0;
      outSampleFf <= '0;
      for (int k = 0; k < 2; k++) begin
        accFf[k] <= '0;
        mixFf[k] <= '0;
      end
      for (int c = 0; c < NCH; c++) begin
        phaseAccFf[c] <= '0;
        for (int k = 0; k < 2; k++) begin
          combOutFf[c][k] <= '0;
          for (int s = 0; s < CIC_STAGES; s++) begin
            combDlyFf[c][s][k] <= '0;
            integFf[c][s][k]   <= '0;
          end
        end
      end
    end else begin
      stateFf     <= nxt_state;
      phaseFf     <= nxt_phase;
      chanFf      <= nxt_chan;
      tapFf       <= nxt_tap;
      stepFf      <= nxt_step;
      wrPtrFf     <= nxt_wrPtr;
      outValidFf  <= nxt_outValid;
      outSampleFf <= nxt_outSample;
      accFf       <= nxt_acc;
      mixFf       <= nxt_mix;
      phaseAccFf  <= nxt_phaseAcc;
      combOutFf   <= nxt_combOut;
      combDlyFf   <= nxt_combDly;
      integFf     <= nxt_integ;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign outValid  = outValidFf;
  assign outSample = outSampleFf;

endmodule

//--- design/mucfc_pkg.sv
/*
  shared constants and types for the multicarrier up-converter filter chain:
  channel count, sample widths, rate-change factors, filter tables and the
  packed carriers used on the ports.
  assumes nothing beyond a systemverilog compiler; compile before the design.
*/
package mucfc_pkg;

  // ------------------------------------------------------------------
  // channel and sample geometry
  // ------------------------------------------------------------------
  localparam int NCH     = 4;          // carriers handled by the chain
  localparam int IN_W    = 12;         // modulator sample width per component
  localparam int OUT_W   = 16;         // output sample width per component
  localparam int PHASE_W = 32;         // oscillator phase accumulator width
  localparam int COEF_W  = 18;         // compensation filter coefficient width

  // ------------------------------------------------------------------
  // rates and rate changes
  // ------------------------------------------------------------------
  localparam int IN_OVERSAMPLE  = 8;    // input samples per symbol
  localparam int OUT_OVERSAMPLE = 256;  // output samples per symbol
  localparam int SHAPE_INTERP   = 1;    // shaping stage bypassed
  localparam int CFIR_INTERP    = 2;    // droop compensator rate change
  localparam int CIC_INTERP     = 16;   // cic rate change
  localparam int TOTAL_INTERP   = SHAPE_INTERP * CFIR_INTERP * CIC_INTERP;
  localparam int PASSBAND_HZ    = 80000;   // passband edge around a carrier
  localparam int STOPBAND_HZ    = 100000;  // stopband edge around a carrier
  localparam int CIC_ATTEN_DB   = 96;      // image rejection target
  localparam int CLK_PERIOD_NS  = 25;      // sys_clk period

  // ------------------------------------------------------------------
  // filter structure
  // ------------------------------------------------------------------
  localparam int NTAP       = 31;      // compensator taps, order 30
  localparam int PH_TAPS    = 16;      // taps per polyphase branch (padded)
  localparam int CIC_STAGES = 4;       // integrator/comb pairs
  localparam int CIC_DIFF   = 1;       // comb differential delay
  localparam int ACC_W      = 34;      // fir accumulator width
  localparam int CIC_W      = 34;      // cic register width, no overflow
  localparam int MIX_W      = 36;      // mixer dot product width
  localparam int CFIR_SHIFT = 16;      // coefficient scale minus interp gain
  localparam int CIC_SHIFT  = 14;      // cic gain 2^12 plus scaling
  localparam int MIX_SHIFT  = 17;      // q15 oscillator plus carrier sum

  localparam logic [PHASE_W-1:0] QUARTER_TURN = 32'h4000_0000;

  // symmetric inverse-sinc lowpass, q17, last slot pads branch 1 to 16 taps
  localparam logic signed [COEF_W-1:0] CFIR_COEF [32] = '{
    18'h00010, 18'h00000, 18'h3ffc0, 18'h00000, 18'h00100, 18'h00080,
    18'h3fd00, 18'h3fe00, 18'h00600, 18'h00500, 18'h3f400, 18'h3f200,
    18'h01800, 18'h02c00, 18'h05000, 18'h08000, 18'h05000, 18'h02c00,
    18'h01800, 18'h3f200, 18'h3f400, 18'h00500, 18'h00600, 18'h3fe00,
    18'h3fd00, 18'h00080, 18'h00100, 18'h00000, 18'h3ffc0, 18'h00000,
    18'h00010, 18'h00000};

  // quarter-wave sine, q15, 16 steps per quarter turn plus the peak
  localparam logic signed [OUT_W-1:0] SIN_QTR [17] = '{
    16'h0000, 16'h0c8c, 16'h18f9, 16'h2528, 16'h30fb, 16'h3c56, 16'h471c,
    16'h5133, 16'h5a82, 16'h62f1, 16'h6a6d, 16'h70e2, 16'h7641, 16'h7a7c,
    16'h7d89, 16'h7f61, 16'h7fff};

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic signed [IN_W-1:0] i;
    logic signed [IN_W-1:0] q;
  } mucfc_in_s;

  typedef struct packed {
    logic signed [OUT_W-1:0] i;
    logic signed [OUT_W-1:0] q;
  } mucfc_out_s;

  typedef mucfc_in_s [NCH-1:0] mucfc_frame_t;
  typedef logic [NCH-1:0][PHASE_W-1:0] mucfc_freq_t;

  typedef enum logic [1:0] {ST_IDLE, ST_MAC, ST_COMB, ST_INTEG} mucfc_state_e;

endpackage

//--- verification/mucfc_filter_chain_asserts.sv
/*
  checker for the filter chain ports: frame handshake, output pacing and
  the number of output samples per frame.
  assumes it is bound to mucfc_filter_chain and sees only its ports.
*/
`timescale 1ns/1ps
module mucfc_filter_chain_asserts
  import mucfc_pkg::*;
(
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire logic                    inValid,
  input wire logic                    inReady,
  input wire mucfc_pkg::mucfc_frame_t inFrame,
  input wire mucfc_pkg::mucfc_freq_t  carrierFreq,
  input wire logic                    outValid,
  input wire mucfc_pkg::mucfc_out_s   outSample
);
  // ------------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------------
  logic       take;          // frame accepted this cycle
  logic [5:0] outCnt_ff;     // outputs since the last accepted frame
  logic [5:0] nxt_outCnt;
  logic       seenFrame_ff;  // at least one frame accepted
  logic       nxt_seenFrame;

  // next values: a take restarts the per-frame count
  always_comb begin
    take          = inValid && inReady;
    nxt_outCnt    = take ? 6'h00 : outCnt_ff + 6'(outValid);
    nxt_seenFrame = seenFrame_ff || take;
  end

  // registers only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      outCnt_ff    <= 6'h00;
      seenFrame_ff <= 1'b0;
    end else begin
      outCnt_ff    <= nxt_outCnt;
      seenFrame_ff <= nxt_seenFrame;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_take_drops_ready: assert property (take |=> !inReady)
    else $error("ready stayed high after a frame was taken");
  a_first_out_time: assert property (take |-> ##73 outValid)
    else $error("first output not 73 cycles after the take");
  a_no_early_out: assert property (take |=> !outValid [*8])
    else $error("output appeared before the stages ran");
  a_out_spacing: assert property (outValid |=> !outValid [*3])
    else $error("outputs closer than four cycles");
  a_sample_holds: assert property (!outValid |-> $stable(outSample))
    else $error("output sample changed without a pulse");
  a_frame_count: assert property (take && seenFrame_ff |-> outCnt_ff + 6'(outValid) == 6'd32)
    else $error("frame did not yield 32 outputs");
  a_busy_whole: assert property (take |-> ##200 !inReady)
    else $error("ready returned before the frame was done");
  a_ready_return: assert property (take |-> ##[1:300] inReady)
    else $error("ready did not return after a frame");

  // main scenarios seen
  c_take: cover property (take);
  c_output: cover property (outValid);
  c_second_frame: cover property (take && seenFrame_ff);
endmodule

bind mucfc_filter_chain mucfc_filter_chain_asserts i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .inValid(inValid), .inReady(inReady), .inFrame(inFrame),
  .carrierFreq(carrierFreq), .outValid(outValid), .outSample(outSample));

//--- verification/mucfc_filter_chain_tb.sv
/*
  self-checking bench for the filter chain: reset state, zero frame,
  mixer phase behaviour and back-to-back frames.
  assumes the partner model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module mucfc_filter_chain_tb;
  import mucfc_pkg::*;

  // ------------------------------------------------------------------
  // signals and counters
  // ------------------------------------------------------------------
  localparam int TIMEOUT_CYC = 5000; // twelve frames of 265 cycles plus slack
  logic         sys_clk;
  logic         rst_n;
  logic         inValid;
  logic         inReady;
  logic         outValid;
  mucfc_frame_t inFrame;
  mucfc_freq_t  carrierFreq;
  mucfc_out_s   outSample;
  int           error_cnt = 0;
  int           cmp_count = 0;
  int           cycleCnt  = 0;

  mucfc_filter_chain i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .inValid(inValid), .inReady(inReady),
    .inFrame(inFrame), .carrierFreq(carrierFreq), .outValid(outValid), .outSample(outSample));
  mucfc_partner u_far (.sys_clk(sys_clk), .rst_n(rst_n), .inReady(inReady), .outValid(outValid),
    .outSample(outSample), .inValid(inValid), .inFrame(inFrame));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // waits for the sink to reach a count, bounded
  task automatic waitOuts(input int want);
    int k;
    k = 0;
    while (u_far.outCnt < want && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
  endtask

  // every carrier gets the same i value and zero q
  function automatic mucfc_frame_t mkFrame(input logic signed [IN_W-1:0] v);
    mucfc_frame_t f;
    for (int c = 0; c < NCH; c++) begin
      f[c].i = v;
      f[c].q = '0;
    end
    return f;
  endfunction

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    check("ready in reset", 32'h1, 32'(inReady));
    check("valid in reset", 32'h0, 32'(outValid));
    check("sample in reset", 32'h0, outSample);
  endtask

  // zero frame: integer path gives exact zeros, 32 samples, fixed latency
  task automatic t_zero_frame();
    int n;
    int base;
    base = u_far.outCnt;
    n    = 0;
    u_far.sendFrame('0);
    check("ready while busy", 32'h0, 32'(inReady));
    while (outValid !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    // the loop starts half a cycle after the take edge and stops half a
    // cycle before the edge that samples the pulse: one edge more
    check("first output latency", 32'd73, 32'(n + 1));
    waitOuts(base + 32);
    repeat (80) @(negedge sys_clk);
    check("outputs per frame", 32'(base + TOTAL_INTERP), 32'(u_far.outCnt));
    for (int k = 0; k < 32; k++) check("zero output", 32'h0, u_far.outLog[(base + k) % 64]);
  endtask

  // mixer: idle oscillator leaves q at zero while eight frames fill half the
  // sixteen-slot delay line; quarter steps then null i or q in turn
  task automatic t_mixer();
    int  base;
    logic anyI;
    anyI = 1'b0;
    for (int f = 0; f < 8; f++) begin
      base = u_far.outCnt;
      u_far.sendFrame(mkFrame(12'h600));
      waitOuts(base + 32);
      for (int k = 0; k < 32; k++) begin
        check("q with idle oscillator", 32'h0, 32'(u_far.outLog[(base + k) % 64].q));
        anyI = anyI | (u_far.outLog[(base + k) % 64].i != 16'h0000);
      end
    end
    check("i passes filters", 32'h1, 32'(anyI));
    @(negedge sys_clk);
    carrierFreq = {NCH{QUARTER_TURN}};
    base        = u_far.outCnt;
    u_far.sendFrame(mkFrame(12'h600));
    waitOuts(base + 32);
    for (int k = 0; k < 32; k += 2) begin
      check("q at even quarter", 32'h0, 32'(u_far.outLog[(base + k) % 64].q));
      check("i at odd quarter", 32'h0, 32'(u_far.outLog[(base + k + 1) % 64].i));
    end
    @(negedge sys_clk);
    carrierFreq = '0;
  endtask

  // back-to-back: second frame held by the source until 32 outputs left
  task automatic t_back_to_back();
    int base;
    base = u_far.outCnt;
    u_far.sendFrame(mkFrame(12'h7ff));
    u_far.sendFrame(mkFrame(12'h801));
    check("outputs before next take", 32'd32, 32'(u_far.outCnt - base));
    waitOuts(base + 64);
    check("outputs for two frames", 32'd64, 32'(u_far.outCnt - base));
  endtask

  // cuts a hang short
  always @(posedge sys_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == TIMEOUT_CYC) begin
      error_cnt++;
      $display("mismatch run length expected under %0d seen %0d", TIMEOUT_CYC, cycleCnt);
      test_done();
    end
  end

  // main sequence
  initial begin
    rst_n       = 1'b0;
    carrierFreq = '0;
    repeat (20) @(negedge sys_clk);
    t_reset();
    rst_n = 1'b1;
    t_zero_frame();
    t_mixer();
    t_back_to_back();
    test_done();
  end
endmodule

//--- verification/mucfc_partner.sv
/*
  far-side model: an upstream modulator offering whole frames and a
  downstream sink that logs every output sample.
  assumes the bench calls sendFrame and reads outCnt and outLog.
*/
`timescale 1ns/1ps
module mucfc_partner
  import mucfc_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    inReady,
  input  wire logic                    outValid,
  input  wire mucfc_pkg::mucfc_out_s   outSample,
  output logic                         inValid,
  output mucfc_pkg::mucfc_frame_t      inFrame
);
  int         outCnt = 0;  // output samples taken by the sink
  mucfc_out_s outLog [64]; // captured samples, wraps after 64

  initial begin
    inValid = 1'b0;
    inFrame = '0;
  end

  // modulator: offer at a falling edge, hold until the taking rising edge
  task automatic sendFrame(input mucfc_frame_t f);
    @(negedge sys_clk);
    inValid = 1'b1;
    inFrame = f;
    while (inReady !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
    inValid = 1'b0;
    inFrame = ~f;   // released lines do not keep the old frame
  endtask

  // sink: takes every pulse, never pushes back
  always @(posedge sys_clk) begin
    if (rst_n && outValid === 1'b1) begin
      outLog[outCnt % 64] <= outSample;
      outCnt              <= outCnt + 1;
    end
  end
endmodule
